// ---- pkg/hfosc_defines.svh ----
/*
  Offsets, field positions, reset values and timings in ns of the
  high-frequency oscillator control block.
  Assumes inclusion by bare name from the design and test files.
*/
`ifndef HFOSC_DEFINES_SVH
`define HFOSC_DEFINES_SVH

`define HFOSC_CTRL_ADDR 8'hb7
`define HFOSC_TRIM_ADDR 8'hbf

`define HFOSC_CTRL_EN_BIT 7
`define HFOSC_CTRL_RDY_BIT 6
`define HFOSC_CTRL_SUSP_BIT 5
`define HFOSC_CTRL_RSVD_MSB 4
`define HFOSC_CTRL_RSVD_LSB 2
`define HFOSC_CTRL_DIV_MSB 1
`define HFOSC_CTRL_DIV_LSB 0

`define HFOSC_CTRL_RESET 8'hc0
`define HFOSC_DIV_RESET 2'h0
// Factory trim value; arbitrary here, set per part
`define HFOSC_TRIM_RESET 8'h80
`define HFOSC_RDATA_IDLE 8'h00

`define HFOSC_CLK_PERIOD_NS 25
`define HFOSC_SETTLE_NS 100

`endif

// ---- pkg/hfosc_pkg.sv ----
/*
  Types of the high-frequency oscillator control block.
  Assumes hfosc_defines.svh is on the include path.
*/
`default_nettype none

package hfosc_pkg;

  // Special-function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // Wake sources for suspend
  typedef struct packed {
    logic [2:0] port_match;
    logic [1:0] cmp_enable;
    logic [1:0] cmp_out;
  } wake_src_t;

  typedef enum logic [1:0] {
    DIV_BY_8 = 2'b00,
    DIV_BY_4 = 2'b01,
    DIV_BY_2 = 2'b10,
    DIV_BY_1 = 2'b11
  } postdiv_t;

  typedef enum logic [2:0] {
    OSC_OFF = 3'b001,
    OSC_SETTLE = 3'b010,
    OSC_READY = 3'b100
  } osc_state_t;

endpackage

`default_nettype wire

// ---- design/hf_postdiv.sv ----
/*
  Post-divider for the oscillator tick stream: 1, 2, 4 or 8.
  Assumes osc_tick_in is a one-cycle pulse per oscillator period.
*/
`timescale 1ns/1ps
`default_nettype none

module hf_postdiv (
  input wire logic mclk_in, // System clock
  input wire logic sys_rst_in, // Async reset, high
  input wire logic osc_tick_in, // Oscillator period pulse
  input wire hfosc_pkg::postdiv_t sel_in, // Divide select
  output logic div_tick_out // Divided pulse
);
  import hfosc_pkg::*;

  logic [2:0] cnt_q, cnt_d;
  logic [2:0] mask;
  logic tick_q, tick_d;

  always_comb begin
    case (sel_in)
      DIV_BY_8: mask = 3'h7;
      DIV_BY_4: mask = 3'h3;
      DIV_BY_2: mask = 3'h1;
      default: mask = 3'h0;
    endcase
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (osc_tick_in) begin
      tick_d = ((cnt_q & mask) == mask);
      cnt_d = cnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign div_tick_out = tick_q;

  chk_div_by_one: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (sel_in == DIV_BY_1 && osc_tick_in) |=> div_tick_out)
    else $error("divide by one missed a tick");

endmodule // hf_postdiv

`default_nettype wire

// ---- design/hf_oscillator_suspend_control.sv ----
/*
  High-frequency oscillator control: enable, ready flag, trim,
  post-divider and suspend with wake events, behind two SFRs.
  Assumes core SFR strobes and wake inputs synchronous to mclk_in;
  the oscillator is modelled as a trim-steered tick generator.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hfosc_defines.svh"

module hf_oscillator_suspend_control #(
  parameter logic [7:0] TRIM_RESET = `HFOSC_TRIM_RESET,
  parameter int SETTLE_CYCLES =
    (`HFOSC_SETTLE_NS + `HFOSC_CLK_PERIOD_NS - 1) / `HFOSC_CLK_PERIOD_NS
) (
  input wire logic mclk_in, // System clock, 40 MHz
  input wire logic sys_rst_in, // Async reset, high
  input wire hfosc_pkg::sfr_req_t sfr_req_in, // SFR access
  input wire hfosc_pkg::wake_src_t wake_in, // Wake sources
  input wire logic ext_src_sel_in, // Another clock source chosen
  output logic [7:0] sfr_rdata_out, // SFR read data
  output logic core_tick_out, // Divided oscillator pulse
  output logic core_hold_out, // Core clock stopped
  output logic hf_selected_out, // Oscillator drives core clock
  output logic hf_running_out // Oscillator running
);
  import hfosc_pkg::*;

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_chk
    $error("SETTLE_CYCLES out of range");
  end

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

  logic ctrl_wr, trim_wr, ctrl_rd, trim_rd;
  logic wake;
  logic osc_on;
  logic div_tick;

  // Control and trim state
  logic en_q, en_d;
  logic susp_q, susp_d;
  postdiv_t div_q, div_d;
  logic [7:0] trim_q, trim_d;
  logic hf_sel_q, hf_sel_d;

  // Oscillator model state
  osc_state_t st_q, st_d;
  logic [7:0] settle_q, settle_d;
  logic [7:0] acc_q, acc_d;
  logic tick_q, tick_d;
  logic [8:0] acc_sum;

  // Output registers
  logic [7:0] rdata_q, rdata_d;
  logic hold_q, hold_d;
  logic run_q, run_d;
  logic core_tick_q, core_tick_d;

  always_comb begin
    ctrl_wr = 1'b0;
    trim_wr = 1'b0;
    ctrl_rd = 1'b0;
    trim_rd = 1'b0;
    if (sfr_req_in.addr == `HFOSC_CTRL_ADDR) begin
      ctrl_wr = sfr_req_in.wr;
      ctrl_rd = sfr_req_in.rd;
    end else if (sfr_req_in.addr == `HFOSC_TRIM_ADDR) begin
      trim_wr = sfr_req_in.wr;
      trim_rd = sfr_req_in.rd;
    end
  end

  assign wake = (|wake_in.port_match) |
                (|(wake_in.cmp_enable & ~wake_in.cmp_out));

  // Register file; reserved write bits are dropped
  always_comb begin
    en_d = en_q;
    div_d = div_q;
    trim_d = trim_q;
    susp_d = susp_q;
    hf_sel_d = ~ext_src_sel_in;
    if (ctrl_wr) begin
      en_d = sfr_req_in.wdata[`HFOSC_CTRL_EN_BIT];
      div_d = postdiv_t'(
        sfr_req_in.wdata[`HFOSC_CTRL_DIV_MSB:`HFOSC_CTRL_DIV_LSB]);
    end
    if (trim_wr) begin
      trim_d = sfr_req_in.wdata;
    end
    // A fresh suspend request wins over a wake in the same cycle
    if (ctrl_wr && sfr_req_in.wdata[`HFOSC_CTRL_SUSP_BIT]) begin
      susp_d = 1'b1;
    end else if (wake) begin
      susp_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_q <= 1'(`HFOSC_CTRL_RESET >> `HFOSC_CTRL_EN_BIT);
      susp_q <= 1'b0;
      div_q <= postdiv_t'(`HFOSC_DIV_RESET);
      trim_q <= TRIM_RESET;
      hf_sel_q <= 1'b1;
    end else begin
      en_q <= en_d;
      susp_q <= susp_d;
      div_q <= div_d;
      trim_q <= trim_d;
      hf_sel_q <= hf_sel_d;
    end
  end

  assign osc_on = en_q & ~susp_q;

  // Ready tracking: a trim change in OSC_READY re-settles the frequency
  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    case (st_q)
      OSC_OFF: begin
        if (osc_on) begin
          st_d = OSC_SETTLE;
          settle_d = 8'h00;
        end
      end
      OSC_SETTLE: begin
        if (!osc_on) begin
          st_d = OSC_OFF;
        end else if (settle_q == SETTLE_LAST) begin
          st_d = OSC_READY;
        end else begin
          settle_d = settle_q + 8'h01;
        end
      end
      OSC_READY: begin
        if (!osc_on) begin
          st_d = OSC_OFF;
        end else if (trim_wr) begin
          st_d = OSC_SETTLE;
          settle_d = 8'h00;
        end
      end
      default: begin
        st_d = OSC_OFF;
      end
    endcase
  end

  // Phase accumulator: larger trim gives a shorter period
  always_comb begin
    acc_sum = {1'b0, acc_q} + {1'b0, trim_q} + 9'h001;
    acc_d = acc_q;
    tick_d = 1'b0;
    if (osc_on) begin
      acc_d = acc_sum[7:0];
      tick_d = acc_sum[8];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= OSC_READY;
      settle_q <= 8'h00;
      acc_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      st_q <= st_d;
      settle_q <= settle_d;
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  hf_postdiv u_postdiv (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .osc_tick_in(tick_q),
    .sel_in(div_q),
    .div_tick_out(div_tick)
  );

  // Outputs; holding the clock keeps core state, so it resumes in place
  always_comb begin
    hold_d = susp_q & hf_sel_q;
    run_d = osc_on;
    core_tick_d = div_tick;
    rdata_d = `HFOSC_RDATA_IDLE;
    if (ctrl_rd) begin
      rdata_d = {en_q, (st_q == OSC_READY), susp_q, 3'b000, div_q};
    end else if (trim_rd) begin
      rdata_d = trim_q;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= `HFOSC_RDATA_IDLE;
      hold_q <= 1'b0;
      run_q <= 1'b1;
      core_tick_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hold_q <= hold_d;
      run_q <= run_d;
      core_tick_q <= core_tick_d;
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign core_hold_out = hold_q;
  assign hf_selected_out = hf_sel_q;
  assign hf_running_out = run_q;
  assign core_tick_out = core_tick_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  chk_source_select: assert property (
    !ext_src_sel_in |=> hf_selected_out)
    else $error("oscillator not selected as source");

  chk_suspend_entry: assert property (
    ctrl_wr && sfr_req_in.wdata[5] |=> susp_q ##1 !tick_q)
    else $error("suspend write did not stop oscillator");

  chk_core_held: assert property (
    susp_q && hf_sel_q |=> core_hold_out)
    else $error("core clock not held in suspend");

  chk_wake_resume: assert property (
    susp_q && wake && !ctrl_wr |=> !susp_q ##1 hf_running_out || !en_q)
    else $error("wake did not restart oscillator");

  chk_enable_off: assert property (
    !en_q |=> !hf_running_out)
    else $error("oscillator runs while disabled");

  chk_ready_flag: assert property (
    $rose(st_q == OSC_READY) |-> $past(osc_on, 1) && $past(osc_on, 2))
    else $error("ready flag rose without a running oscillator");

  chk_reserved_zero: assert property (
    ctrl_rd |=> sfr_rdata_out[4:2] == 3'b000)
    else $error("reserved bits not zero");

  chk_trim_write: assert property (
    trim_wr |=> trim_q == $past(sfr_req_in.wdata))
    else $error("trim write lost");

  chk_other_source: assert property (
    !hf_sel_q |=> !core_hold_out)
    else $error("core held with another source");

  cov_suspend_wake: cover property (susp_q ##1 wake ##1 !susp_q);
  cov_settle_done: cover property (st_q == OSC_SETTLE ##1 st_q == OSC_READY);
  cov_ext_suspend: cover property (susp_q && !hf_sel_q);

endmodule // hf_oscillator_suspend_control

`default_nettype wire

// ---- test/hf_oscillator_suspend_control_test.sv ----
/*
  Self-checking bench for the oscillator control block.
  Assumes the package and the defines header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hfosc_defines.svh"

module hf_oscillator_suspend_control_test;
  import hfosc_pkg::*;

  localparam logic [7:0] TRIM_INIT = 8'h5a;
  localparam logic [7:0] CTRL = `HFOSC_CTRL_ADDR;
  localparam logic [7:0] TRIM = `HFOSC_TRIM_ADDR;
  localparam logic [6:0] WAKE_IDLE = 7'h03;

  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  sfr_req_t sfr_req = '0;
  wake_src_t wake = WAKE_IDLE;
  logic ext_src_sel = 1'b0;
  logic [7:0] rdata;
  logic core_tick, core_hold, hf_selected, hf_running;
  int errors = 0;
  int tests_run = 0;
  int tick_cnt = 0;
  logic [6:0] wake_tab [5] = '{7'h13, 7'h23, 7'h43, 7'h06, 7'h09};

  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (core_tick === 1'b1) tick_cnt++;

  hf_oscillator_suspend_control #(
    .TRIM_RESET(TRIM_INIT),
    .SETTLE_CYCLES(4)
  ) u_dut (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .sfr_req_in(sfr_req),
    .wake_in(wake),
    .ext_src_sel_in(ext_src_sel),
    .sfr_rdata_out(rdata),
    .core_tick_out(core_tick),
    .core_hold_out(core_hold),
    .hf_selected_out(hf_selected),
    .hf_running_out(hf_running)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk_in);
    sfr_req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk_in);
    sfr_req.rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask

  // Count divided ticks over 64 clocks, one tick of phase slack
  task automatic ticks_chk(input int exp);
    @(negedge mclk_in) tick_cnt = 0;
    repeat (64) @(negedge mclk_in);
    chk1(tick_cnt <= exp && tick_cnt + 1 >= exp, 1'b1);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic t_reset;
    #1 chk1(hf_selected, 1'b1);
    chk1(hf_running, 1'b1);
    rd_chk(CTRL, 8'hc0);
    rd_chk(TRIM, TRIM_INIT);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(8'hb8, 8'h00);
    rd_chk(8'hb8, 8'h00);
    rd_chk(CTRL, 8'hc0);
    wr(CTRL, 8'h83);
    rd_chk(CTRL, 8'hc3);
    wr(TRIM, 8'h7f);
    rd_chk(TRIM, 8'h7f);
    $display("test registers done");
  endtask

  // Trim 7f gives one oscillator tick every two clocks
  task automatic t_divide;
    int div;
    for (int c = 0; c < 4; c++) begin
      wr(CTRL, 8'h80 | c[7:0]);
      // Let pulses of the old ratio drain from the pipeline
      settle(4);
      div = 8 >> c;
      ticks_chk(32 / div);
    end
    wr(CTRL, 8'h80);
    $display("test divider done");
  endtask

  task automatic t_enable;
    wr(CTRL, 8'h00);
    settle(2);
    chk1(hf_running, 1'b0);
    rd_chk(CTRL, 8'h00);
    wr(CTRL, 8'h80);
    rd_chk(CTRL, 8'h80);
    settle(8);
    chk1(hf_running, 1'b1);
    rd_chk(CTRL, 8'hc0);
    $display("test enable done");
  endtask

  task automatic t_suspend;
    for (int i = 0; i < 5; i++) begin
      chk1(hf_selected, 1'b1);
      wr(CTRL, 8'ha0);
      settle(3);
      chk1(hf_running, 1'b0);
      chk1(core_hold, 1'b1);
      ticks_chk(0);
      rd_chk(CTRL, 8'ha0);
      wake <= 7'h05;
      settle(4);
      chk1(core_hold, 1'b1);
      wake <= wake_tab[i];
      settle(3);
      chk1(core_hold, 1'b0);
      chk1(hf_running, 1'b1);
      wake <= WAKE_IDLE;
      settle(8);
      rd_chk(CTRL, 8'hc0);
    end
    $display("test suspend done");
  endtask

  task automatic t_ext_source;
    ext_src_sel <= 1'b1;
    settle(2);
    chk1(hf_selected, 1'b0);
    wr(CTRL, 8'ha0);
    settle(3);
    chk1(hf_running, 1'b0);
    chk1(core_hold, 1'b0);
    wake <= wake_tab[0];
    settle(3);
    chk1(hf_running, 1'b1);
    wake <= WAKE_IDLE;
    ext_src_sel <= 1'b0;
    settle(2);
    chk1(hf_selected, 1'b1);
    $display("test other source done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_regs();
    t_divide();
    t_enable();
    t_suspend();
    t_ext_source();
    conclude();
  end

  initial begin
    #1ms;
    errors++;
    conclude();
  end

endmodule // hf_oscillator_suspend_control_test
`default_nettype wire
